// [uart_channel_register_select.v]
// Notes on behaviour
// - Three address lines plus register bits select
// - Address 000 reads receive data, writes transmit
// - Address 001 reaches interrupt enables
// - 010 reads interrupt source, writes queue control
// - Line format, modem control, scratch are read/write
// - Line and modem state read-only, writes ignored
// - Line format bit 7 opens divisor bytes
// - Value 0xBF opens features and flow characters
// - Features bit 4 and modem bit 6 open thresholds
// - Ready summary needs both selects, bit2, no loopback
// - Prescaler bit writable only with enhanced enable
// - Enhanced-only fields ignore writes unless enabled
// - Shift stage feeds a 64-entry receive queue
// - Receive framing follows line format settings
// - Queue disabled: location zero, newest overwrites
// - Full queue drops incoming character
// - Break, framing, parity flags stored per character
// - Only receive data read advances the queue
`timescale 1ns/10ps
`include "uart_channel_map.vh"

module uart_channel_register_select #(
  parameter CHANNEL_IS_B = 0,
  parameter DEPTH_LOG2 = 6
) (
  input wire CLK,
  input wire RESETN,
  input wire [2:0] ADDR,
  input wire [7:0] DATA_IN,
  output reg [7:0] DATA_OUT,
  output wire DATA_OE,
  input wire READ_N,
  input wire WRITE_N,
  input wire CHANNEL_A_SELECT_N,
  input wire CHANNEL_B_SELECT_N,
  input wire RX_LINE,
  input wire [5:0] INT_SOURCE_CODE,
  input wire [7:0] MODEM_STATE,
  input wire TX_HOLD_EMPTY,
  input wire TX_ALL_EMPTY,
  input wire OWN_TX_READY,
  input wire PEER_TX_READY,
  input wire PEER_RX_READY,
  output reg [7:0] TX_DATA,
  output reg TX_LOAD,
  output reg TX_QUEUE_CLEAR,
  output reg [15:0] DIVISOR,
  output reg [7:0] INT_ENABLES,
  output reg [7:0] QUEUE_CONTROL,
  output reg [7:0] LINE_FORMAT,
  output reg [7:0] MODEM_CONTROL,
  output reg [7:0] FEATURES,
  output reg [7:0] RESUME_ONE,
  output reg [7:0] RESUME_TWO,
  output reg [7:0] PAUSE_ONE,
  output reg [7:0] PAUSE_TWO,
  output reg [7:0] THRESHOLD,
  output reg [7:0] TRIGGER_LEVELS,
  output wire RX_READY
);

  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam S_IDLE = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_PARITY = 3'h3;
  localparam S_STOP = 3'h4;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [14:0] pin_s1;
  reg [14:0] pin_s2;
  reg rx_s1;
  reg rx_s2;
  reg read_n_d;
  reg write_n_d;

  always @(posedge CLK) begin
    if (!RESETN) begin
      pin_s1 <= 15'h7fff;
      pin_s2 <= 15'h7fff;
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      read_n_d <= 1'b1;
      write_n_d <= 1'b1;
    end else begin
      pin_s1 <= {READ_N, WRITE_N, CHANNEL_A_SELECT_N, CHANNEL_B_SELECT_N,
                 ADDR, DATA_IN};
      pin_s2 <= pin_s1;
      rx_s1 <= RX_LINE;
      rx_s2 <= rx_s1;
      read_n_d <= pin_s2[14];
      write_n_d <= pin_s2[13];
    end
  end

  wire read_n_s = pin_s2[14];
  wire write_n_s = pin_s2[13];
  wire sel_a_n = pin_s2[12];
  wire sel_b_n = pin_s2[11];
  wire [2:0] addr_s = pin_s2[10:8];
  wire [7:0] data_s = pin_s2[7:0];
  wire selected = (CHANNEL_IS_B != 0) ? !sel_b_n : !sel_a_n;
  wire read_active = selected && !read_n_s;
  wire read_end = read_n_s && !read_n_d;
  wire write_strobe = selected && !write_n_s && write_n_d;

  // --------------------------------------------------------------------------
  // View decode
  // --------------------------------------------------------------------------
  wire enhanced = FEATURES[`EF_ENHANCED];
  wire feature_view = (LINE_FORMAT == `FEATURE_VIEW_CODE);
  wire divisor_view = LINE_FORMAT[`LFC_DIVISOR_VIEW];
  wire thresh_view = enhanced && MODEM_CONTROL[`MLC_THRESH_VIEW];
  wire ready_view = !sel_a_n && !sel_b_n &&
                    MODEM_CONTROL[`MLC_READY_VIEW] &&
                    !MODEM_CONTROL[`MLC_LOOPBACK];
  wire at_divisor = divisor_view && (addr_s == `ADDR_DIVISOR_LOW ||
                    addr_s == `ADDR_DIVISOR_HIGH);
  wire at_flow = feature_view && (addr_s == `ADDR_FEATURES ||
                 addr_s[2]);
  wire at_thresh = !at_flow && thresh_view &&
                   (addr_s == `ADDR_THRESHOLD ||
                    addr_s == `ADDR_TRIGGER);
  wire at_ready = !at_flow && !at_thresh && ready_view &&
                  addr_s == `ADDR_READY_SUMMARY;
  wire at_default = !at_divisor && !at_flow && !at_thresh &&
                    !at_ready;

  // --------------------------------------------------------------------------
  // Receive queue storage
  // --------------------------------------------------------------------------
  reg [10:0] queue_mem [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] rd_ptr;
  reg [DEPTH_LOG2-1:0] wr_ptr;
  reg [DEPTH_LOG2:0] count;
  reg [DEPTH_LOG2:0] err_count;
  reg overrun;
  wire queue_on = QUEUE_CONTROL[`QC_ENABLE];
  wire [10:0] head = queue_on ? queue_mem[rd_ptr] : queue_mem[0];
  wire has_data = (count != {(DEPTH_LOG2+1){1'b0}});
  wire full = (count == DEPTH[DEPTH_LOG2:0]);
  assign RX_READY = has_data;

  // --------------------------------------------------------------------------
  // Read data path
  // --------------------------------------------------------------------------
  wire [7:0] line_state = {err_count != {(DEPTH_LOG2+1){1'b0}},
                           TX_ALL_EMPTY, TX_HOLD_EMPTY,
                           has_data ? head[10:8] : 3'h0,
                           overrun, has_data};
  wire rx_ready_a = (CHANNEL_IS_B != 0) ? PEER_RX_READY : has_data;
  wire rx_ready_b = (CHANNEL_IS_B != 0) ? has_data : PEER_RX_READY;
  wire tx_ready_a = (CHANNEL_IS_B != 0) ? PEER_TX_READY : OWN_TX_READY;
  wire tx_ready_b = (CHANNEL_IS_B != 0) ? OWN_TX_READY : PEER_TX_READY;
  reg [7:0] scratch;
  reg [7:0] read_value;

  always @* begin
    read_value = 8'h00;
    if (at_divisor) begin
      read_value = addr_s[0] ? DIVISOR[15:8] : DIVISOR[7:0];
    end else if (at_flow) begin
      case (addr_s)
        `ADDR_FEATURES: read_value = FEATURES;
        `ADDR_RESUME_ONE: read_value = RESUME_ONE;
        `ADDR_RESUME_TWO: read_value = RESUME_TWO;
        `ADDR_PAUSE_ONE: read_value = PAUSE_ONE;
        default: read_value = PAUSE_TWO;
      endcase
    end else if (at_thresh) begin
      read_value = addr_s[0] ? TRIGGER_LEVELS : THRESHOLD;
    end else if (at_ready) begin
      read_value = {2'h0, rx_ready_b, rx_ready_a, 2'h0,
                    tx_ready_b, tx_ready_a};
    end else begin
      case (addr_s)
        `ADDR_HOLDING: read_value = head[7:0];
        `ADDR_ENABLES: read_value = INT_ENABLES;
        `ADDR_SOURCE: read_value = {queue_on, queue_on,
                                    INT_SOURCE_CODE};
        `ADDR_LINE_FORMAT: read_value = LINE_FORMAT;
        `ADDR_MODEM_CONTROL: read_value = MODEM_CONTROL;
        `ADDR_LINE_STATE: read_value = line_state;
        `ADDR_MODEM_STATE: read_value = MODEM_STATE;
        default: read_value = scratch;
      endcase
    end
  end

  // Data stands in a flop; pop and overrun clear wait for strobe release
  reg pop_pending;
  reg state_read_pending;
  assign DATA_OE = read_active;

  always @(posedge CLK) begin
    if (!RESETN) begin
      DATA_OUT <= `RESET_BYTE;
      pop_pending <= 1'b0;
      state_read_pending <= 1'b0;
    end else if (read_active) begin
      DATA_OUT <= read_value;
      pop_pending <= at_default && addr_s == `ADDR_HOLDING;
      state_read_pending <= at_default && addr_s == `ADDR_LINE_STATE;
    end else if (read_end) begin
      pop_pending <= 1'b0;
      state_read_pending <= 1'b0;
    end
  end

  wire pop = read_end && pop_pending && has_data;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RESETN) begin
      DIVISOR <= {`RESET_BYTE, `RESET_BYTE};
      INT_ENABLES <= `RESET_BYTE;
      QUEUE_CONTROL <= `RESET_BYTE;
      LINE_FORMAT <= `RESET_BYTE;
      MODEM_CONTROL <= `RESET_BYTE;
      FEATURES <= `RESET_BYTE;
      RESUME_ONE <= `RESET_BYTE;
      RESUME_TWO <= `RESET_BYTE;
      PAUSE_ONE <= `RESET_BYTE;
      PAUSE_TWO <= `RESET_BYTE;
      THRESHOLD <= `RESET_BYTE;
      TRIGGER_LEVELS <= `RESET_BYTE;
      scratch <= `RESET_BYTE;
      TX_DATA <= `RESET_BYTE;
      TX_LOAD <= 1'b0;
      TX_QUEUE_CLEAR <= 1'b0;
    end else begin
      TX_LOAD <= 1'b0;
      TX_QUEUE_CLEAR <= 1'b0;
      if (write_strobe) begin
        if (at_divisor) begin
          if (addr_s[0]) begin
            DIVISOR[15:8] <= data_s;
          end else begin
            DIVISOR[7:0] <= data_s;
          end
        end else if (at_flow) begin
          case (addr_s)
            `ADDR_FEATURES: FEATURES <= data_s;
            `ADDR_RESUME_ONE: RESUME_ONE <= data_s;
            `ADDR_RESUME_TWO: RESUME_TWO <= data_s;
            `ADDR_PAUSE_ONE: PAUSE_ONE <= data_s;
            default: PAUSE_TWO <= data_s;
          endcase
        end else if (at_thresh) begin
          if (addr_s[0]) begin
            TRIGGER_LEVELS <= data_s;
          end else begin
            THRESHOLD <= data_s;
          end
        end else if (!at_ready) begin
          case (addr_s)
            `ADDR_HOLDING: begin
              TX_DATA <= data_s;
              TX_LOAD <= 1'b1;
            end
            `ADDR_ENABLES: begin
              INT_ENABLES[3:0] <= data_s[3:0];
              if (enhanced) begin
                INT_ENABLES[7:4] <= data_s[7:4];
              end
            end
            `ADDR_SOURCE: begin
              QUEUE_CONTROL[7:6] <= data_s[7:6];
              QUEUE_CONTROL[3] <= data_s[3];
              QUEUE_CONTROL[`QC_ENABLE] <= data_s[`QC_ENABLE];
              if (enhanced) begin
                QUEUE_CONTROL[5:4] <= data_s[5:4];
              end
              TX_QUEUE_CLEAR <= data_s[`QC_TX_CLEAR];
            end
            `ADDR_LINE_FORMAT: LINE_FORMAT <= data_s;
            `ADDR_MODEM_CONTROL: begin
              MODEM_CONTROL[6] <= data_s[6];
              MODEM_CONTROL[4:0] <= data_s[4:0];
              if (enhanced) begin
                MODEM_CONTROL[`MLC_PRESCALE] <= data_s[7];
                MODEM_CONTROL[`MLC_ANY_RESUME] <= data_s[5];
              end
            end
            `ADDR_SCRATCH: scratch <= data_s;
            default: ;
          endcase
        end
      end
    end
  end

  wire rx_clear = write_strobe && at_default && addr_s == `ADDR_SOURCE &&
                  data_s[`QC_RX_CLEAR];

  // --------------------------------------------------------------------------
  // Oversample tick: divisor with optional divide by 4
  // --------------------------------------------------------------------------
  reg [1:0] pre_count;
  reg [15:0] div_count;
  reg tick;
  wire pre_step = !MODEM_CONTROL[`MLC_PRESCALE] || pre_count == 2'h3;

  always @(posedge CLK) begin
    if (!RESETN) begin
      pre_count <= 2'h0;
      div_count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      pre_count <= pre_count + 2'h1;
      tick <= 1'b0;
      if (pre_step && DIVISOR != 16'h0000) begin
        if (div_count >= DIVISOR - 16'h0001) begin
          div_count <= 16'h0000;
          tick <= 1'b1;
        end else begin
          div_count <= div_count + 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive shift stage
  // --------------------------------------------------------------------------
  reg [2:0] state;
  reg [3:0] sample;
  reg [2:0] bit_index;
  reg [7:0] rx_shift_stage;
  reg parity_err;
  reg any_high;
  reg push;
  reg [10:0] push_word;
  wire [2:0] last_bit = {1'b1, LINE_FORMAT[1:0]};
  wire parity_calc = ^rx_shift_stage;
  wire parity_bad = LINE_FORMAT[`LFC_STICK_PARITY] ?
                    (rx_s2 == LINE_FORMAT[`LFC_EVEN_PARITY]) :
                    (LINE_FORMAT[`LFC_EVEN_PARITY] ?
                     (parity_calc ^ rx_s2) : !(parity_calc ^ rx_s2));

  always @(posedge CLK) begin
    if (!RESETN) begin
      state <= S_IDLE;
      sample <= 4'h0;
      bit_index <= 3'h0;
      rx_shift_stage <= `RESET_BYTE;
      parity_err <= 1'b0;
      any_high <= 1'b0;
      push <= 1'b0;
      push_word <= 11'h000;
    end else begin
      push <= 1'b0;
      if (tick) begin
        sample <= sample + 4'h1;
        case (state)
          S_IDLE: begin
            sample <= 4'h0;
            if (!rx_s2) begin
              state <= S_START;
            end
          end
          S_START: begin
            if (sample == `OVERSAMPLE_HALF) begin
              sample <= 4'h0;
              bit_index <= 3'h0;
              rx_shift_stage <= `RESET_BYTE;
              parity_err <= 1'b0;
              any_high <= 1'b0;
              state <= rx_s2 ? S_IDLE : S_DATA;
            end
          end
          S_DATA: begin
            if (sample == `OVERSAMPLE_LAST) begin
              rx_shift_stage[bit_index] <= rx_s2;
              any_high <= any_high | rx_s2;
              bit_index <= bit_index + 3'h1;
              if (bit_index == last_bit) begin
                state <= LINE_FORMAT[`LFC_PARITY_ON] ? S_PARITY :
                         S_STOP;
              end
            end
          end
          S_PARITY: begin
            if (sample == `OVERSAMPLE_LAST) begin
              parity_err <= parity_bad;
              any_high <= any_high | rx_s2;
              state <= S_STOP;
            end
          end
          default: begin
            if (sample == `OVERSAMPLE_LAST) begin
              push <= 1'b1;
              push_word <= {!any_high && !rx_s2, !rx_s2, parity_err,
                            rx_shift_stage};
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive queue control
  // --------------------------------------------------------------------------
  wire head_err = |head[10:8];
  wire new_err = |push_word[10:8];
  wire accept = push && (!queue_on || !full || pop);

  always @(posedge CLK) begin
    if (!RESETN) begin
      rd_ptr <= {DEPTH_LOG2{1'b0}};
      wr_ptr <= {DEPTH_LOG2{1'b0}};
      count <= {(DEPTH_LOG2+1){1'b0}};
      err_count <= {(DEPTH_LOG2+1){1'b0}};
      overrun <= 1'b0;
    end else if (rx_clear) begin
      rd_ptr <= {DEPTH_LOG2{1'b0}};
      wr_ptr <= {DEPTH_LOG2{1'b0}};
      count <= {(DEPTH_LOG2+1){1'b0}};
      err_count <= {(DEPTH_LOG2+1){1'b0}};
    end else if (!queue_on) begin
      if (push) begin
        queue_mem[0] <= push_word;
        count <= {{DEPTH_LOG2{1'b0}}, 1'b1};
        err_count <= {{DEPTH_LOG2{1'b0}}, new_err};
      end else if (pop) begin
        count <= {(DEPTH_LOG2+1){1'b0}};
        err_count <= {(DEPTH_LOG2+1){1'b0}};
      end
    end else begin
      if (accept) begin
        queue_mem[wr_ptr] <= push_word;
        wr_ptr <= wr_ptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
      end
      count <= count + {{DEPTH_LOG2{1'b0}}, accept} -
               {{DEPTH_LOG2{1'b0}}, pop};
      err_count <= err_count + {{DEPTH_LOG2{1'b0}}, accept && new_err} -
                   {{DEPTH_LOG2{1'b0}}, pop && head_err};
    end
    if (RESETN) begin
      if (push && (queue_on ? (full && !pop) : (has_data && !pop))) begin
        overrun <= 1'b1;
      end else if (read_end && state_read_pending) begin
        overrun <= 1'b0;
      end
    end
  end

endmodule // uart_channel_register_select

// [uart_channel_map.vh]
`ifndef UART_CHANNEL_MAP_VH
`define UART_CHANNEL_MAP_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_HOLDING 3'h0
`define ADDR_ENABLES 3'h1
`define ADDR_SOURCE 3'h2
`define ADDR_LINE_FORMAT 3'h3
`define ADDR_MODEM_CONTROL 3'h4
`define ADDR_LINE_STATE 3'h5
`define ADDR_MODEM_STATE 3'h6
`define ADDR_SCRATCH 3'h7
`define ADDR_DIVISOR_LOW 3'h0
`define ADDR_DIVISOR_HIGH 3'h1
`define ADDR_FEATURES 3'h2
`define ADDR_RESUME_ONE 3'h4
`define ADDR_RESUME_TWO 3'h5
`define ADDR_PAUSE_ONE 3'h6
`define ADDR_PAUSE_TWO 3'h7
`define ADDR_THRESHOLD 3'h6
`define ADDR_TRIGGER 3'h7
`define ADDR_READY_SUMMARY 3'h7

// ----------------------------------------------------------------------------
// Key values and field positions
// ----------------------------------------------------------------------------
`define FEATURE_VIEW_CODE 8'hbf
`define LFC_DIVISOR_VIEW 7
`define LFC_STICK_PARITY 5
`define LFC_EVEN_PARITY 4
`define LFC_PARITY_ON 3
`define EF_ENHANCED 4
`define MLC_PRESCALE 7
`define MLC_THRESH_VIEW 6
`define MLC_ANY_RESUME 5
`define MLC_LOOPBACK 4
`define MLC_READY_VIEW 2
`define QC_ENABLE 0
`define QC_RX_CLEAR 1
`define QC_TX_CLEAR 2

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define OVERSAMPLE_HALF 4'h7
`define OVERSAMPLE_LAST 4'hf

`endif

// [uart_channel_register_select_chk.sv]
`timescale 1ns/10ps
`include "uart_channel_map.vh"

module uart_channel_register_select_chk (
  input wire CLK,
  input wire RESETN,
  input wire READ_N,
  input wire WRITE_N,
  input wire CHANNEL_A_SELECT_N,
  input wire DATA_OE,
  input wire TX_LOAD,
  input wire TX_QUEUE_CLEAR,
  input wire RX_READY,
  input wire [15:0] DIVISOR,
  input wire [7:0] INT_ENABLES,
  input wire [7:0] QUEUE_CONTROL,
  input wire [7:0] LINE_FORMAT,
  input wire [7:0] MODEM_CONTROL,
  input wire [7:0] FEATURES,
  input wire [7:0] RESUME_ONE,
  input wire [7:0] RESUME_TWO,
  input wire [7:0] PAUSE_ONE,
  input wire [7:0] PAUSE_TWO,
  input wire [7:0] THRESHOLD,
  input wire [7:0] TRIGGER_LEVELS
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // ------------------------------------------------------------
  // Quiet bus spans, longer than the strobe synchronisers
  // ------------------------------------------------------------
  sequence s_no_read;
    (READ_N || CHANNEL_A_SELECT_N) [*4];
  endsequence
  sequence s_no_write;
    WRITE_N [*6];
  endsequence
  sequence s_no_access;
    (READ_N && WRITE_N) [*6];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_oe_idle;
    s_no_read |-> !DATA_OE;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data enable without a selected read");
  property p_regs_quiet;
    s_no_write |->
      $stable({DIVISOR, INT_ENABLES, LINE_FORMAT, MODEM_CONTROL});
  endproperty
  a_regs_quiet: assert property (p_regs_quiet)
    else $error("register changed without a write");
  property p_rx_hold;
    s_no_access |-> !$fell(RX_READY);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive queue emptied without a read");
  property p_load;
    TX_LOAD |-> !$past(WRITE_N, 2) ##1 !TX_LOAD;
  endproperty
  a_load: assert property (p_load)
    else $error("transmit load pulse malformed");
  property p_txclr;
    TX_QUEUE_CLEAR |-> !$past(WRITE_N, 2) ##1 !TX_QUEUE_CLEAR;
  endproperty
  a_txclr: assert property (p_txclr)
    else $error("transmit queue clear pulse malformed");
  property p_prescale;
    $changed(MODEM_CONTROL[7]) |-> $past(FEATURES[4]);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler bit changed while locked");
  property p_enh;
    $changed({INT_ENABLES[7:4], QUEUE_CONTROL[5:4], MODEM_CONTROL[5]})
      |-> $past(FEATURES[4]);
  endproperty
  a_enh: assert property (p_enh)
    else $error("enhanced field changed while locked");
  property p_divisor;
    $changed(DIVISOR) |-> $past(LINE_FORMAT[7]);
  endproperty
  a_divisor: assert property (p_divisor)
    else $error("divisor changed outside divisor view");
  property p_flow;
    $changed({FEATURES, RESUME_ONE, RESUME_TWO, PAUSE_ONE, PAUSE_TWO})
      |-> $past(LINE_FORMAT) == `FEATURE_VIEW_CODE;
  endproperty
  a_flow: assert property (p_flow)
    else $error("feature view register changed outside its view");
  property p_thresh;
    $changed({THRESHOLD, TRIGGER_LEVELS})
      |-> $past(FEATURES[4]) && $past(MODEM_CONTROL[6]);
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold register changed while hidden");
endmodule // uart_channel_register_select_chk

bind uart_channel_register_select uart_channel_register_select_chk chk_i (
  .CLK(CLK), .RESETN(RESETN), .READ_N(READ_N), .WRITE_N(WRITE_N),
  .CHANNEL_A_SELECT_N(CHANNEL_A_SELECT_N), .DATA_OE(DATA_OE),
  .TX_LOAD(TX_LOAD), .RX_READY(RX_READY), .DIVISOR(DIVISOR),
  .TX_QUEUE_CLEAR(TX_QUEUE_CLEAR),
  .INT_ENABLES(INT_ENABLES), .QUEUE_CONTROL(QUEUE_CONTROL),
  .LINE_FORMAT(LINE_FORMAT), .MODEM_CONTROL(MODEM_CONTROL),
  .FEATURES(FEATURES), .RESUME_ONE(RESUME_ONE), .RESUME_TWO(RESUME_TWO),
  .PAUSE_ONE(PAUSE_ONE), .PAUSE_TWO(PAUSE_TWO), .THRESHOLD(THRESHOLD),
  .TRIGGER_LEVELS(TRIGGER_LEVELS)
);

// [uart_line_sender.sv]
`timescale 1ns/10ps

module uart_line_sender #(
  parameter BIT_CYCLES = 16
) (
  input wire clk,
  output reg line
);
  initial line = 1'b1;

  // Frame bits go out lowest first, line idles high after
  task automatic send(input [10:0] frame, input integer nbits);
    integer i;
    integer k;
    begin
      for (i = 0; i < nbits; i = i + 1) begin
        line <= frame[i];
        for (k = 0; k < BIT_CYCLES; k = k + 1) @(posedge clk);
      end
      line <= 1'b1;
      repeat (2 * BIT_CYCLES) @(posedge clk);
    end
  endtask
endmodule // uart_line_sender

// [tb.sv]
`timescale 1ns/10ps

module tb;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] din = 8'h00;
  reg rd_n = 1'b1;
  reg wr_n = 1'b1;
  reg sel_a_n = 1'b1;
  reg sel_b_n = 1'b1;
  reg own_tx = 1'b1;
  reg peer_rx = 1'b1;
  wire rx_line;
  wire [7:0] data_out;
  wire [7:0] tx_data;
  wire [15:0] divisor;
  wire [7:0] threshold;
  wire [7:0] trig;
  wire rx_ready;
  integer mismatches = 0;
  integer total_checks = 0;
  integer i;

  always #5 clk = ~clk;

  uart_line_sender line_model (.clk(clk), .line(rx_line));

  uart_channel_register_select DUT (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .DATA_IN(din),
    .DATA_OUT(data_out), .DATA_OE(), .READ_N(rd_n), .WRITE_N(wr_n),
    .CHANNEL_A_SELECT_N(sel_a_n), .CHANNEL_B_SELECT_N(sel_b_n),
    .RX_LINE(rx_line), .INT_SOURCE_CODE(6'h2c), .MODEM_STATE(8'h96),
    .TX_HOLD_EMPTY(1'b1), .TX_ALL_EMPTY(1'b0), .OWN_TX_READY(own_tx),
    .PEER_TX_READY(!own_tx), .PEER_RX_READY(peer_rx), .TX_DATA(tx_data),
    .TX_LOAD(), .TX_QUEUE_CLEAR(), .DIVISOR(divisor), .INT_ENABLES(),
    .QUEUE_CONTROL(), .LINE_FORMAT(), .MODEM_CONTROL(), .FEATURES(),
    .RESUME_ONE(), .RESUME_TWO(), .PAUSE_ONE(), .PAUSE_TWO(),
    .THRESHOLD(threshold), .TRIGGER_LEVELS(trig), .RX_READY(rx_ready)
  );

  // ------------------------------------------------------------
  // Host access and comparison
  // ------------------------------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      din <= d;
      sel_a_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (5) @(posedge clk);
      wr_n <= 1'b1;
      repeat (4) @(posedge clk);
      sel_a_n <= 1'b1;
    end
  endtask

  // Strobe held past the three-edge answer, select kept past release
  task rc(input [2:0] a, input both, input [7:0] exp);
    reg [7:0] q;
    begin
      @(posedge clk);
      addr <= a;
      sel_a_n <= 1'b0;
      sel_b_n <= !both;
      rd_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1 q = data_out;
      @(posedge clk);
      rd_n <= 1'b1;
      repeat (4) @(posedge clk);
      sel_a_n <= 1'b1;
      sel_b_n <= 1'b1;
      chk(q, exp);
    end
  endtask

  function [10:0] fr(input [7:0] d, input stop);
    fr = {1'b1, stop, d, 1'b0};
  endfunction

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wr(3'h7, 8'h5a);
    rc(3'h7, 0, 8'h5a);
    wr(3'h3, 8'h03);
    rc(3'h3, 0, 8'h03);
    wr(3'h4, 8'h83);
    rc(3'h4, 0, 8'h03);
    wr(3'h1, 8'hff);
    rc(3'h1, 0, 8'h0f);
    wr(3'h5, 8'hff);
    wr(3'h6, 8'hff);
    rc(3'h3, 0, 8'h03);
    rc(3'h6, 0, 8'h96);
    rc(3'h5, 0, 8'h20);
    rc(3'h2, 0, 8'h2c);
    wr(3'h0, 8'h77);
    chk(tx_data, 8'h77);
    wr(3'h2, 8'h01);
    rc(3'h2, 0, 8'hec);
    $display("default view test done");
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rc(3'h0, 0, 8'h01);
    rc(3'h1, 0, 8'h00);
    chk(divisor[7:0], 8'h01);
    wr(3'h3, 8'h03);
    rc(3'h1, 0, 8'h0f);
    $display("divisor view test done");
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    for (i = 4; i < 8; i = i + 1) wr(i[2:0], 8'h30 + i[7:0]);
    rc(3'h2, 0, 8'h10);
    for (i = 4; i < 8; i = i + 1) rc(i[2:0], 0, 8'h30 + i[7:0]);
    wr(3'h3, 8'h03);
    rc(3'h7, 0, 8'h5a);
    wr(3'h1, 8'hf5);
    rc(3'h1, 0, 8'hf5);
    wr(3'h4, 8'he4);
    rc(3'h4, 0, 8'he4);
    wr(3'h6, 8'h21);
    wr(3'h7, 8'h43);
    chk(threshold, 8'h21);
    chk(trig, 8'h43);
    rc(3'h6, 0, 8'h21);
    wr(3'h4, 8'h04);
    rc(3'h7, 1, 8'h21);
    own_tx <= 1'b0;
    rc(3'h7, 1, 8'h22);
    rc(3'h7, 0, 8'h5a);
    wr(3'h4, 8'h14);
    rc(3'h7, 1, 8'h5a);
    wr(3'h4, 8'h00);
    $display("enhanced view test done");
    line_model.send(fr(8'ha5, 1'b1), 10);
    line_model.send(fr(8'h3c, 1'b0), 10);
    rc(3'h5, 0, 8'ha1);
    rc(3'h5, 0, 8'ha1);
    rc(3'h0, 0, 8'ha5);
    rc(3'h5, 0, 8'ha9);
    rc(3'h0, 0, 8'h3c);
    rc(3'h5, 0, 8'h20);
    wr(3'h3, 8'h1b);
    line_model.send(11'h402, 11);
    rc(3'h5, 0, 8'ha5);
    rc(3'h0, 0, 8'h01);
    wr(3'h3, 8'h03);
    for (i = 0; i < 65; i = i + 1) line_model.send(fr(i[7:0], 1'b1), 10);
    rc(3'h5, 0, 8'h23);
    for (i = 0; i < 64; i = i + 1) rc(3'h0, 0, i[7:0]);
    rc(3'h5, 0, 8'h20);
    wr(3'h3, 8'h00);
    line_model.send(11'h06a, 7);
    rc(3'h0, 0, 8'h15);
    wr(3'h3, 8'h03);
    wr(3'h2, 8'h06);
    line_model.send(fr(8'h11, 1'b1), 10);
    line_model.send(fr(8'h22, 1'b1), 10);
    chk({7'h00, rx_ready}, 8'h01);
    rc(3'h0, 0, 8'h22);
    chk({7'h00, rx_ready}, 8'h00);
    $display("receive test done");
    tally_and_finish;
  end
endmodule // tb
